// ==== pkg/mid_pkg.sv ====
// constants and carrier types for the midrange instruction decoder
// assumes a single core clock; program and data memories sit outside
// ==========================================================================
package mid_pkg;
  localparam int          PC_W          = 13;
  localparam int          FA_W          = 7;
  localparam logic [1:0]  QUARTERS_LAST = 2'h3;        // four clocks per cycle
  localparam logic [1:0]  GRP_BYTE      = 2'h0;
  localparam logic [1:0]  GRP_BIT       = 2'h1;
  localparam logic [1:0]  GRP_BRANCH    = 2'h2;
  localparam logic [1:0]  GRP_LIT       = 2'h3;
  localparam logic [PC_W-1:0] PC_RESET  = 13'h0000;
  localparam logic [7:0]  W_RESET       = 8'h00;
  localparam logic [FA_W-1:0] FA_STATUS = 7'h03;
  localparam logic [FA_W-1:0] FA_LATCH  = 7'h0a;
  localparam logic [FA_W-1:0] FA_TIMER0 = 7'h01;
  localparam int          ST_C          = 0;
  localparam int          ST_DC         = 1;
  localparam int          ST_Z          = 2;
  localparam int          ST_PD         = 3;
  localparam int          ST_TO         = 4;
  localparam logic [7:0]  STATUS_RESET  = 8'h18;
  localparam logic [13:0] OP_NOP        = 14'h0000;
  localparam logic [13:0] OP_RETURN     = 14'h0008;
  localparam logic [13:0] OP_RETFIE     = 14'h0009;
  localparam logic [13:0] OP_SLEEP      = 14'h0063;
  localparam logic [13:0] OP_WDCLR      = 14'h0064;

  typedef enum logic [3:0] {
    mid_movwf_t_unused, mid_sub, mid_dec, mid_ior, mid_and, mid_xor, mid_add, mid_mov,
    mid_com, mid_inc, mid_decsz, mid_rrf, mid_rlf, mid_swap, mid_incsz
  } mid_byte_op_t;

  typedef struct packed {
    logic            we;
    logic [FA_W-1:0] addr;
    logic [7:0]      data;
  } mid_fwr_t;
endpackage : mid_pkg

// ==== hw/mid_core.sv ====
// instruction decode and execute for a midrange 14-bit core
// assumes prog_data is valid for prog_addr by the last quarter, and file data
// combinationally readable at file_raddr; ports read back with pin levels
//
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module mid_core #(
  parameter int STACK_DEPTH = 8
) (
  input  wire logic                      clk,           // core clock
  input  wire logic                      rst_b,         // async reset, low
  output logic [mid_pkg::PC_W-1:0]       prog_addr,     // fetch address
  input  wire logic [13:0]               prog_data,     // fetched word
  output logic [mid_pkg::FA_W-1:0]       file_raddr,    // file read address
  input  wire logic [7:0]                file_rdata,    // file read data (pins for ports)
  output mid_pkg::mid_fwr_t              file_wr,       // file write, one clk pulse
  input  wire logic                      timer_zero_count_presc_on, // prescaler owned by timer zero
  output logic                           timer_zero_count_presc_clr,// prescaler clear pulse
  output logic                           wdog_clr,      // watchdog and prescaler clear
  output logic                           sleep_req,     // stop oscillator, level
  output logic [7:0]                     acc_out,       // accumulator
  output logic [7:0]                     status_out,    // status flags
  output logic                           cycle_strobe   // last quarter of a cycle
);
  import mid_pkg::*;

  // ========================================================================
  // quarter counter
  // quarter 3 is the only execute slot; the rest leave fetch and file read time
  logic [1:0] quarter_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      quarter_q <= 2'h0;
    end else begin
      quarter_q <= quarter_q + 2'h1;
    end
  end
  wire logic exec = (quarter_q == QUARTERS_LAST);
  assign cycle_strobe = exec;

  // ========================================================================
  // architectural state
  logic [PC_W-1:0] pc_q;
  logic [7:0]      w_q;
  logic [7:0]      st_q;
  logic [7:0]      latch_q;
  logic            flush_q;                      // this cycle is a no-operation
  logic            halt_q;
  logic            hold_q;                       // branch target already in pc
  logic [PC_W-1:0] stack_q [STACK_DEPTH];
  logic [$clog2(STACK_DEPTH)-1:0] sp_q;

  // ========================================================================
  // field decode
  // a flushed cycle decodes as a no-operation, so no field can leak a write
  wire logic [13:0]     ins  = flush_q ? OP_NOP : prog_data;
  wire logic [1:0]      grp  = ins[13:12];
  wire logic [3:0]      bop  = ins[11:8];
  wire logic            dst  = ins[7];
  wire logic [FA_W-1:0] fa   = ins[6:0];
  wire logic [1:0]      tbop = ins[11:10];
  wire logic [2:0]      bnum = ins[9:7];
  wire logic [7:0]      lit  = ins[7:0];
  wire logic [7:0]      fv   = file_rdata;

  assign file_raddr = fa;
  assign prog_addr  = pc_q;

  // ========================================================================
  // execute
  logic [7:0]      res;
  logic            wr_f;
  logic            wr_w;
  logic [7:0]      st_d;
  logic [PC_W-1:0] pc_d;
  logic            skip;
  logic            push;
  logic            pop;
  logic            pc_load;
  logic            go_sleep;
  logic            do_wdclr;
  logic [8:0]      sum;
  logic [4:0]      nib;
  logic [7:0]      bmask;

  // defaults describe a no-operation; each opcode overrides only what it owns
  always_comb begin
    res      = 8'h00;
    wr_f     = 1'b0;
    wr_w     = 1'b0;
    st_d     = st_q;
    pc_d     = pc_q + 13'h0001;
    skip     = 1'b0;
    push     = 1'b0;
    pop      = 1'b0;
    pc_load  = 1'b0;
    go_sleep = 1'b0;
    do_wdclr = 1'b0;
    sum      = 9'h000;
    nib      = 5'h00;
    bmask    = 8'h01 << bnum;
    case (grp)
      GRP_BYTE: begin
        wr_f = dst;
        wr_w = !dst;
        case (bop)
          // opcode zero with destination clear holds the control words
          4'h0: begin
            wr_w = 1'b0;
            wr_f = dst;
            res  = w_q;
            if (!dst) begin
              case (ins)
                OP_RETURN, OP_RETFIE: begin
                  pop  = 1'b1;
                  pc_load = 1'b1;
                  pc_d = stack_q[sp_q - 1'b1];
                  skip = 1'b1;
                end
                OP_WDCLR: begin
                  do_wdclr     = 1'b1;
                  st_d[ST_TO]  = 1'b1;
                  st_d[ST_PD]  = 1'b1;
                end
                OP_SLEEP: begin
                  do_wdclr     = 1'b1;
                  go_sleep     = 1'b1;
                  st_d[ST_TO]  = 1'b1;
                  st_d[ST_PD]  = 1'b0;
                end
                default: ;
              endcase
            end
          end
          4'h1: begin
            res       = 8'h00;
            st_d[ST_Z] = 1'b1;
          end
          // subtraction adds the two's complement, so carry means no borrow
          4'h2, 4'h7: begin
            sum = (bop == 4'h7) ? ({1'b0, fv} + {1'b0, w_q})
                                : ({1'b0, fv} + {1'b0, ~w_q} + 9'h001);
            nib = (bop == 4'h7) ? ({1'b0, fv[3:0]} + {1'b0, w_q[3:0]})
                                : ({1'b0, fv[3:0]} + {1'b0, ~w_q[3:0]} + 5'h01);
            res         = sum[7:0];
            st_d[ST_C]  = sum[8];
            st_d[ST_DC] = nib[4];
            st_d[ST_Z]  = (sum[7:0] == 8'h00);
          end
          4'h3: begin
            res        = fv - 8'h01;
            st_d[ST_Z] = (res == 8'h00);
          end
          4'h4: begin
            res        = w_q | fv;
            st_d[ST_Z] = (res == 8'h00);
          end
          4'h5: begin
            res        = w_q & fv;
            st_d[ST_Z] = (res == 8'h00);
          end
          4'h6: begin
            res        = w_q ^ fv;
            st_d[ST_Z] = (res == 8'h00);
          end
          4'h8: begin
            res        = fv;
            st_d[ST_Z] = (res == 8'h00);
          end
          4'h9: begin
            res        = ~fv;
            st_d[ST_Z] = (res == 8'h00);
          end
          4'ha: begin
            res        = fv + 8'h01;
            st_d[ST_Z] = (res == 8'h00);
          end
          // a zero result skips by flushing the next word, not by stepping twice
          4'hb: begin
            res  = fv - 8'h01;
            skip = (res == 8'h00);
          end
          4'hc: begin
            res        = {st_q[ST_C], fv[7:1]};
            st_d[ST_C] = fv[0];
          end
          4'hd: begin
            res        = {fv[6:0], st_q[ST_C]};
            st_d[ST_C] = fv[7];
          end
          4'he: begin
            res = {fv[3:0], fv[7:4]};
          end
          default: begin
            res  = fv + 8'h01;
            skip = (res == 8'h00);
          end
        endcase
      end
      // bit number selects a one-hot mask; the tests leave the file untouched
      GRP_BIT: begin
        case (tbop)
          2'h0: begin
            res  = fv & ~bmask;
            wr_f = 1'b1;
          end
          2'h1: begin
            res  = fv | bmask;
            wr_f = 1'b1;
          end
          2'h2: skip = ((fv & bmask) == 8'h00);
          default: skip = ((fv & bmask) != 8'h00);
        endcase
      end
      // bit 11 clear marks a call, set marks a plain jump
      GRP_BRANCH: begin
        pc_d = {latch_q[4:3], ins[10:0]};
        push = !ins[11];
        skip = 1'b1;
        pc_load = 1'b1;
      end
      // undefined literal codes fall to the inner default and change nothing
      default: begin
        wr_w = 1'b1;
        casez (ins[11:8])
          4'b00??: begin
            res = lit;
          end
          4'b01??: begin
            res  = lit;
            pop  = 1'b1;
            pc_load = 1'b1;
            pc_d = stack_q[sp_q - 1'b1];
            skip = 1'b1;
          end
          4'b1000: begin
            res        = w_q | lit;
            st_d[ST_Z] = (res == 8'h00);
          end
          4'b1001: begin
            res        = w_q & lit;
            st_d[ST_Z] = (res == 8'h00);
          end
          4'b1010: begin
            res        = w_q ^ lit;
            st_d[ST_Z] = (res == 8'h00);
          end
          4'b110?, 4'b111?: begin
            sum = ins[9] ? ({1'b0, lit} + {1'b0, w_q})
                         : ({1'b0, lit} + {1'b0, ~w_q} + 9'h001);
            nib = ins[9] ? ({1'b0, lit[3:0]} + {1'b0, w_q[3:0]})
                         : ({1'b0, lit[3:0]} + {1'b0, ~w_q[3:0]} + 5'h01);
            res         = sum[7:0];
            st_d[ST_C]  = sum[8];
            st_d[ST_DC] = nib[4];
            st_d[ST_Z]  = (sum[7:0] == 8'h00);
          end
          default: wr_w = 1'b0;
        endcase
      end
    endcase
  end

  // ========================================================================
  // commit at the last quarter; held off entirely while halted
  wire logic commit = exec && !halt_q;
  wire logic fw     = commit && wr_f;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pc_q    <= PC_RESET;
      flush_q <= 1'b0;
    end else if (commit) begin
      if (!flush_q) begin
        pc_q <= pc_d;
      end else if (!hold_q) begin
        pc_q <= pc_q + 13'h0001;
      end
      flush_q <= !flush_q && skip;
    end
  end

  // a load already points pc at its target; the flushed cycle must not move it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_q <= 1'b0;
    end else if (commit) begin
      hold_q <= !flush_q && pc_load;
    end
  end

  // accumulator only moves on an executed instruction
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      w_q <= W_RESET;
    end else if (commit && wr_w) begin
      w_q <= res;
    end
  end

  // status written by an instruction loses to the flags it computes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= STATUS_RESET;
    end else if (fw && fa == FA_STATUS) begin
      st_q <= {res[7:5], st_q[ST_TO], st_q[ST_PD], st_d[2:0]};
    end else if (commit) begin
      st_q <= st_d;
    end
  end

  // only bits four and three of the upper latch feed branch targets
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      latch_q <= 8'h00;
    end else if (fw && fa == FA_LATCH) begin
      latch_q <= res;
    end
  end

  // stack wraps like a ring; overflow overwrites the oldest entry
  // no underflow guard: a return on an empty stack reads the ring's last slot
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sp_q <= '0;
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stack_q[i] <= '0;
      end
    end else if (commit && push) begin
      stack_q[sp_q] <= pc_q + 13'h0001;
      sp_q          <= sp_q + 1'b1;
    end else if (commit && pop) begin
      sp_q <= sp_q - 1'b1;
    end
  end

  // only reset restarts the core; no wake input clears the halt
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      halt_q <= 1'b0;
    end else if (commit && go_sleep) begin
      halt_q <= 1'b1;
    end
  end

  // ========================================================================
  // outputs
  // write and clear pulses stand one clock, registered on the execute edge itself
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      file_wr <= '0;
    end else begin
      file_wr.we   <= fw;
      file_wr.addr <= fa;
      file_wr.data <= res;
    end
  end

  // prescaler clear rides with the timer-zero write it belongs to
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_zero_count_presc_clr <= 1'b0;
    end else begin
      timer_zero_count_presc_clr <= fw && fa == FA_TIMER0 && timer_zero_count_presc_on;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wdog_clr <= 1'b0;
    end else begin
      wdog_clr <= commit && do_wdclr;
    end
  end

  assign sleep_req  = halt_q;
  assign acc_out    = w_q;
  assign status_out = st_q;
endmodule : mid_core

// ==== verif/mid_prog_mem.sv ====
// program memory model feeding fourteen-bit words to the core
// assumes the testbench loads words through the mem array
`timescale 1ns/1ps
module mid_prog_mem (
  input  wire logic [mid_pkg::PC_W-1:0] prog_addr, // fetch address
  output logic [13:0]                   prog_data  // word at that address
);
  import mid_pkg::*;
  logic [13:0] mem [0:8191];

  initial begin
    for (int a = 0; a < 8192; a++) begin
      mem[a] = OP_NOP;
    end
  end
  // asynchronous read, word ready long before the last quarter
  assign prog_data = mem[prog_addr];
endmodule : mid_prog_mem

// ==== verif/mid_checker.sv ====
// port assertions for mid_core
// assumes one clock and a bind from the testbench top
`timescale 1ns/1ps
module mid_checker #(
  parameter int STACK_DEPTH = 8
) (
  input wire logic                     clk,            // core clock
  input wire logic                     rst_b,          // async reset
  input wire logic [mid_pkg::PC_W-1:0] prog_addr,      // fetch address
  input wire logic [13:0]              prog_data,      // fetched word
  input wire logic [mid_pkg::FA_W-1:0] file_raddr,     // file read address
  input wire logic [7:0]               file_rdata,     // file read data
  input wire mid_pkg::mid_fwr_t        file_wr,        // file write
  input wire logic                     timer_zero_count_presc_on,  // prescaler owner
  input wire logic                     timer_zero_count_presc_clr, // prescaler clear
  input wire logic                     wdog_clr,       // watchdog clear
  input wire logic                     sleep_req,      // halted
  input wire logic [7:0]               acc_out,        // accumulator
  input wire logic [7:0]               status_out,     // status flags
  input wire logic                     cycle_strobe    // last quarter
);
  import mid_pkg::*;
  logic go;

  // flushed cycles present address 0, so a matching address marks a real execute
  assign go = cycle_strobe && !sleep_req && file_raddr == prog_data[6:0];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ==========================================================================
  // assertions
  property p_quarter;
    cycle_strobe |=> !cycle_strobe [*3] ##1 cycle_strobe;
  endproperty
  a_quarter: assert property (p_quarter)
    else $error("strobe spacing not four clocks");
  property p_wdog;
    go && prog_data == OP_WDCLR |=> wdog_clr && status_out[ST_TO] && status_out[ST_PD];
  endproperty
  a_wdog: assert property (p_wdog)
    else $error("watchdog clear effects missing");
  property p_sleep;
    go && prog_data == OP_SLEEP |=> wdog_clr && sleep_req && status_out[ST_TO]
      && !status_out[ST_PD];
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep effects missing");
  property p_halt;
    sleep_req |=> sleep_req && $stable(prog_addr) && $stable(acc_out);
  endproperty
  a_halt: assert property (p_halt)
    else $error("core ran while halted");
  property p_wr_slot;
    file_wr.we |-> $past(cycle_strobe);
  endproperty
  a_wr_slot: assert property (p_wr_slot)
    else $error("file write outside its slot");
  property p_dest_w;
    go && prog_data[13:12] == 2'b00 && !prog_data[7] |=> !file_wr.we;
  endproperty
  a_dest_w: assert property (p_dest_w)
    else $error("file written with destination zero");
  property p_clear;
    go && prog_data[13:7] == 7'h03 && prog_data[6:0] != 7'h00 |=> file_wr.we
      && file_wr.data == 8'h00 && file_wr.addr == $past(file_raddr) && status_out[ST_Z];
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear register wrong");
  property p_presc;
    timer_zero_count_presc_clr == (file_wr.we && file_wr.addr == FA_TIMER0 && $past(timer_zero_count_presc_on));
  endproperty
  a_presc: assert property (p_presc)
    else $error("prescaler clear mismatch");
endmodule : mid_checker

// ==== verif/midrange_instruction_decoder_test.sv ====
// self-checking bench for mid_core with program memory and file model
// assumes mid_pkg compiled first
`timescale 1ns/1ps
module midrange_instruction_decoder_test;
  import mid_pkg::*;
  localparam logic [15:0] ANY = 16'hffff;
  logic             clk;
  logic             rst_b;
  logic [PC_W-1:0]  prog_addr;
  logic [13:0]      prog_data;
  logic [FA_W-1:0]  file_raddr;
  logic [7:0]       file_rdata;
  mid_fwr_t         file_wr;
  logic             timer_zero_count_presc_on;
  logic             timer_zero_count_presc_clr;
  logic             wdog_clr;
  logic             sleep_req;
  logic [7:0]       acc_out;
  logic [7:0]       status_out;
  logic             cycle_strobe;
  logic [7:0]       fmem [0:127];
  logic [13:0]      pq [$];
  int               n_errors;
  int               samples_checked;

  mid_core u_dut (.clk(clk), .rst_b(rst_b), .prog_addr(prog_addr), .prog_data(prog_data),
    .file_raddr(file_raddr), .file_rdata(file_rdata), .file_wr(file_wr),
    .timer_zero_count_presc_on(timer_zero_count_presc_on), .timer_zero_count_presc_clr(timer_zero_count_presc_clr), .wdog_clr(wdog_clr),
    .sleep_req(sleep_req), .acc_out(acc_out), .status_out(status_out),
    .cycle_strobe(cycle_strobe));
  mid_prog_mem u_pmem (.prog_addr(prog_addr), .prog_data(prog_data));

  // ==========================================================================
  // file register model
  assign file_rdata = fmem[file_raddr];
  always @(posedge clk) begin
    if (file_wr.we === 1'b1) begin
      fmem[file_wr.addr] <= file_wr.data;
    end
  end
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ==========================================================================
  // helpers
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic start();
    @(posedge clk);
    rst_b <= 1'b0;
    timer_zero_count_presc_on <= 1'b0;
    @(posedge clk);
    for (int a = 0; a < 8192; a++) begin
      u_pmem.mem[a] = OP_NOP;
    end
    for (int a = 0; a < 128; a++) begin
      fmem[a] = 8'h00;
    end
  endtask : start

  task automatic load(input logic [12:0] a);
    foreach (pq[i]) begin
      u_pmem.mem[a + 13'(i)] = pq[i];
    end
  endtask : load

  task automatic free_rst();
    repeat (7) @(posedge clk);
    rst_b <= 1'b1;
  endtask : free_rst

  // one instruction cycle; pc of ANY is left unchecked
  task automatic run(input logic [7:0] w, input logic [7:0] st, input logic [15:0] pc);
    int i;
    i = 0;
    while (cycle_strobe !== 1'b1) begin
      @(posedge clk);
      #1;
      i++;
      if (i > 8) begin
        n_errors++;
        report_and_stop();
      end
    end
    @(posedge clk);
    #1;
    chk({8'h00, acc_out}, {8'h00, w});
    chk({8'h00, status_out}, {8'h00, st});
    if (pc != ANY) begin
      chk({3'h0, prog_addr}, pc);
    end
  endtask : run

  // ==========================================================================
  // scenarios
  task automatic t_literal();
    start();
    pq = '{14'h3e0f, 14'h3f01, 14'h3eff, 14'h39f0};
    load(13'h0000);
    free_rst();
    run(8'h0f, 8'h18, 16'h0001);
    run(8'h10, 8'h1a, 16'h0002);
    run(8'h0f, 8'h19, 16'h0003);
    run(8'h00, 8'h1d, 16'h0004);
    $display("literal test done");
  endtask : t_literal

  task automatic t_file();
    start();
    pq = '{14'h3e0b, 14'h0720, 14'h07a0, 14'h0520, 14'h09a0, 14'h01a0, 14'h0920, 14'h0100};
    load(13'h0000);
    fmem[32] = 8'h35;
    free_rst();
    run(8'h0b, 8'h18, 16'h0001);
    run(8'h40, 8'h1a, 16'h0002);
    run(8'h40, 8'h18, 16'h0003);
    run(8'h40, 8'h18, 16'h0004);
    chk({8'h00, fmem[32]}, 16'h0075);
    run(8'h40, 8'h18, 16'h0005);
    run(8'h40, 8'h1c, 16'h0006);
    chk({8'h00, fmem[32]}, 16'h008a);
    run(8'hff, 8'h18, 16'h0007);
    chk({8'h00, fmem[32]}, 16'h0000);
    run(8'h00, 8'h1c, 16'h0008);
    $display("file test done");
  endtask : t_file

  task automatic t_bits();
    start();
    pq = '{14'h14a1, 14'h1021, 14'h18a1, 14'h1821, 14'h3e01, 14'h1ca1, 14'h3e02, 14'h1c21,
           14'h3e04};
    load(13'h0000);
    fmem[33] = 8'h81;
    free_rst();
    run(8'h00, 8'h18, 16'h0001);
    run(8'h00, 8'h18, 16'h0002);
    run(8'h00, 8'h18, 16'h0003);
    run(8'h00, 8'h18, ANY);
    run(8'h00, 8'h18, 16'h0005);
    run(8'h00, 8'h18, ANY);
    run(8'h00, 8'h18, 16'h0007);
    run(8'h00, 8'h18, 16'h0008);
    run(8'h04, 8'h18, 16'h0009);
    chk({8'h00, fmem[33]}, 16'h0082);
    $display("bit test done");
  endtask : t_bits

  task automatic t_flow();
    start();
    pq = '{14'h160a, 14'h158a, 14'h2805};
    load(13'h0000);
    pq = '{14'h2010, 14'h2014, 14'h3e01};
    load(13'h1805);
    pq = '{14'h0ba2, 14'h0ba2, 14'h3e01, 14'h0008, 14'h3455};
    load(13'h1810);
    fmem[34] = 8'h02;
    free_rst();
    run(8'h00, 8'h18, 16'h0001);
    run(8'h00, 8'h18, 16'h0002);
    run(8'h00, 8'h18, ANY);
    run(8'h00, 8'h18, 16'h1805);
    run(8'h00, 8'h18, ANY);
    run(8'h00, 8'h18, 16'h1810);
    run(8'h00, 8'h18, 16'h1811);
    run(8'h00, 8'h18, ANY);
    run(8'h00, 8'h18, 16'h1813);
    run(8'h00, 8'h18, ANY);
    run(8'h00, 8'h18, 16'h1806);
    run(8'h00, 8'h18, ANY);
    run(8'h00, 8'h18, 16'h1814);
    run(8'h55, 8'h18, ANY);
    run(8'h55, 8'h18, 16'h1807);
    run(8'h56, 8'h18, 16'h1808);
    chk({8'h00, fmem[34]}, 16'h0000);
    $display("flow test done");
  endtask : t_flow

  task automatic t_special();
    start();
    pq = '{14'h0181, 14'h0181, OP_WDCLR, OP_SLEEP, 14'h3e01};
    load(13'h0000);
    timer_zero_count_presc_on <= 1'b1;
    free_rst();
    run(8'h00, 8'h1c, 16'h0001);
    chk({15'h0, timer_zero_count_presc_clr}, 16'h0001);
    @(posedge clk);
    timer_zero_count_presc_on <= 1'b0;
    run(8'h00, 8'h1c, 16'h0002);
    chk({15'h0, timer_zero_count_presc_clr}, 16'h0000);
    run(8'h00, 8'h1c, 16'h0003);
    chk({15'h0, wdog_clr}, 16'h0001);
    run(8'h00, 8'h14, ANY);
    chk({14'h0, wdog_clr, sleep_req}, 16'h0003);
    repeat (12) @(posedge clk);
    #1;
    chk({7'h0, sleep_req, acc_out}, 16'h0100);
    $display("special test done");
  endtask : t_special

  initial begin
    n_errors = 0;
    samples_checked = 0;
    rst_b = 1'b0;
    timer_zero_count_presc_on = 1'b0;
    t_literal();
    t_file();
    t_bits();
    t_flow();
    t_special();
    report_and_stop();
  end
endmodule : midrange_instruction_decoder_test

bind mid_core mid_checker #(.STACK_DEPTH(STACK_DEPTH)) u_chk (.clk(clk), .rst_b(rst_b),
  .prog_addr(prog_addr), .prog_data(prog_data), .file_raddr(file_raddr),
  .file_rdata(file_rdata), .file_wr(file_wr), .timer_zero_count_presc_on(timer_zero_count_presc_on),
  .timer_zero_count_presc_clr(timer_zero_count_presc_clr), .wdog_clr(wdog_clr), .sleep_req(sleep_req),
  .acc_out(acc_out), .status_out(status_out), .cycle_strobe(cycle_strobe));
